// ==== hw/temp_mon_pkg.sv ====
// Purpose: constants and types for the temperature monitor alarm block
// Assumes: byte-wide register access through an address pointer
// Notes:   read and write addresses differ for several registers
package temp_mon_pkg;

    // ==========================================================
    // register addresses (read side, then write side)
    localparam logic [7:0] A_LOCAL_T   = 8'h00;
    localparam logic [7:0] A_REMOTE_HI = 8'h01;
    localparam logic [7:0] A_STATUS    = 8'h02;
    localparam logic [7:0] A_CFG_RD    = 8'h03;
    localparam logic [7:0] A_RATE_RD   = 8'h04;
    localparam logic [7:0] A_LHI_RD    = 8'h05;
    localparam logic [7:0] A_LLO_RD    = 8'h06;
    localparam logic [7:0] A_RHI_RD    = 8'h07;
    localparam logic [7:0] A_RLO_RD    = 8'h08;
    localparam logic [7:0] A_CFG_WR    = 8'h09;
    localparam logic [7:0] A_RATE_WR   = 8'h0a;
    localparam logic [7:0] A_LHI_WR    = 8'h0b;
    localparam logic [7:0] A_LLO_WR    = 8'h0c;
    localparam logic [7:0] A_RHI_WR    = 8'h0d;
    localparam logic [7:0] A_RLO_WR    = 8'h0e;
    localparam logic [7:0] A_ONESHOT   = 8'h0f;
    localparam logic [7:0] A_REMOTE_LO = 8'h10;
    localparam logic [7:0] A_OFS_HI    = 8'h11;
    localparam logic [7:0] A_OFS_LO    = 8'h12;
    localparam logic [7:0] A_RHI_LO    = 8'h13;
    localparam logic [7:0] A_RLO_LO    = 8'h14;
    localparam logic [7:0] A_RCRIT     = 8'h19;
    localparam logic [7:0] A_LCRIT     = 8'h20;
    localparam logic [7:0] A_HYST      = 8'h21;
    localparam logic [7:0] A_FILTER    = 8'h22;
    localparam logic [7:0] A_MAKER     = 8'hfe;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_CFG    = 8'h00;
    localparam logic [7:0] RST_RATE   = 8'h08;
    localparam logic [7:0] RST_HIGH   = 8'h55;
    localparam logic [7:0] RST_LOW    = 8'h00;
    localparam logic [7:0] RST_CRIT   = 8'h6c;
    localparam logic [7:0] RST_HYST   = 8'h0a;
    localparam logic [7:0] RST_FILTER = 8'h01;
    localparam logic [7:0] RST_PTR    = 8'h00;

    // ==========================================================
    // field positions
    localparam int ST_BUSY   = 7;
    localparam int ST_LHI    = 6;
    localparam int ST_OPEN   = 2;
    localparam int ST_RCRIT  = 1;
    localparam int ST_LCRIT  = 0;
    localparam int CFG_MASK  = 7;
    localparam int CFG_STBY  = 6;
    localparam int CFG_MODE  = 5;
    localparam int FLT_TMO   = 7;
    localparam int FLT_MSB   = 3;
    localparam int FLT_LSB   = 1;
    localparam int RATE_MSB  = 3;
    localparam logic [2:0] CNT_MAX = 3'h4;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        CV_IDLE = 2'b01,
        CV_BUSY = 2'b10
    } conv_e;

    typedef struct packed {
        logic [7:0] local_t;
        logic [9:0] remote_t;
        logic       remote_open;
    } result_s;

endpackage

// ==== hw/temp_monitor_alarm_regs.sv ====
// Purpose: status flags, alarm and critical outputs, register map
// Assumes: serial engine and converter run on ref_clk, byte strobes
// Notes:   alarm and critical outputs are active low levels; pin drivers sit outside
module temp_monitor_alarm_regs #(
    parameter logic [7:0] MAKER_CODE = 8'h5a  // arbitrary value
) (
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     ce,
    input  wire logic                     wr_valid,
    input  wire logic                     wr_first,
    input  wire logic [7:0]               wr_data,
    input  wire logic                     rd_req,
    input  wire logic                     ara_ack,
    input  wire logic                     conv_tick,
    input  wire logic                     conv_done,
    input  wire temp_mon_pkg::result_s    result,
    output logic      [7:0]               rd_data,
    output logic                          rd_valid,
    output logic                          conv_start,
    output logic                          alarm_out_n,
    output logic                          overtemp_out_n,
    output logic                          bus_timeout_en,
    output logic      [3:0]               rate_code
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0]        ptr;
        logic [7:0]        cfg;
        logic [7:0]        rate;
        logic [7:0]        lhi;
        logic [7:0]        llo;
        logic [7:0]        rhi_h;
        logic [7:0]        rlo_h;
        logic [7:0]        rhi_l;
        logic [7:0]        rlo_l;
        logic [7:0]        ofs_h;
        logic [7:0]        ofs_l;
        logic [7:0]        rcrit;
        logic [7:0]        lcrit;
        logic [7:0]        hyst;
        logic [7:0]        filt;
        logic [7:0]        local_t;
        logic [9:0]        remote_t;
        logic              open_lvl;
        logic [3:0]        raw;
        logic [3:0]        cond;
        logic [3:0][2:0]   cnt;
        logic [6:0]        flags;
        logic              alarm_latch;
        logic              oneshot;
        temp_mon_pkg::conv_e conv;
        logic              conv_start;
        logic [7:0]        rd_data;
        logic              rd_valid;
        logic              alarm_n;
        logic              overtemp_n;
    } state_s;

    state_s          st_r;
    state_s          st_nxt;
    logic [9:0]      ofs;
    logic [11:0]     sum;
    logic [9:0]      rc;
    logic [3:0]      oob;
    logic [3:0]      trip;
    logic [3:0][2:0] cnt_new;
    logic [2:0]      need;
    logic            done;
    logic            mode2;
    logic            fault;
    logic [7:0]      rd_mux;

    // true when val has fallen to lim minus hyst
    function automatic logic at_floor(input logic [7:0] val,
                                      input logic [7:0] lim,
                                      input logic [7:0] hy);
        logic signed [9:0] v;
        logic signed [9:0] f;
        v = $signed({2'b00, val});
        f = $signed({2'b00, lim}) - $signed({2'b00, hy});
        return v <= f;
    endfunction

    // ==========================================================
    // remote offset correction, clamped to the result range
    assign ofs = {st_r.ofs_h, st_r.ofs_l[7:6]};
    assign sum = 12'($signed({2'b00, result.remote_t})
               + $signed({{2{ofs[9]}}, ofs}));
    assign rc  = sum[11] ? 10'h000
               : (sum[10] ? 10'h3ff : sum[9:0]);

    // ==========================================================
    // limit compares on a fresh reading
    assign oob[0] = result.local_t > st_r.lhi;
    assign oob[1] = result.local_t <= st_r.llo;
    assign oob[2] = rc > {st_r.rhi_h, st_r.rhi_l[7:6]};
    assign oob[3] = rc <= {st_r.rlo_h, st_r.rlo_l[7:6]};

    // unlisted codes fall back to one reading
    always_comb begin
        case (st_r.filt[temp_mon_pkg::FLT_MSB:temp_mon_pkg::FLT_LSB])
            3'h1:    need = 3'h2;
            3'h3:    need = 3'h3;
            3'h7:    need = 3'h4;
            default: need = 3'h1;
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lim
            assign cnt_new[gi] = !oob[gi] ? 3'h0
                : (st_r.cnt[gi] == temp_mon_pkg::CNT_MAX
                   ? temp_mon_pkg::CNT_MAX : st_r.cnt[gi] + 3'h1);
            assign trip[gi] = oob[gi] && (cnt_new[gi] >= need);
        end
    endgenerate

    assign done  = (st_r.conv == temp_mon_pkg::CV_BUSY) && conv_done;
    assign mode2 = st_r.cfg[temp_mon_pkg::CFG_MODE];
    assign fault = (|st_r.raw) || st_r.open_lvl;

    // ==========================================================
    // read mux
    always_comb begin
        case (st_r.ptr)
            temp_mon_pkg::A_LOCAL_T:   rd_mux = st_r.local_t;
            temp_mon_pkg::A_REMOTE_HI: rd_mux = st_r.remote_t[9:2];
            temp_mon_pkg::A_STATUS:    rd_mux = {st_r.conv ==
                temp_mon_pkg::CV_BUSY, st_r.flags};
            temp_mon_pkg::A_CFG_RD:    rd_mux = st_r.cfg;
            temp_mon_pkg::A_RATE_RD:   rd_mux = st_r.rate;
            temp_mon_pkg::A_LHI_RD:    rd_mux = st_r.lhi;
            temp_mon_pkg::A_LLO_RD:    rd_mux = st_r.llo;
            temp_mon_pkg::A_RHI_RD:    rd_mux = st_r.rhi_h;
            temp_mon_pkg::A_RLO_RD:    rd_mux = st_r.rlo_h;
            temp_mon_pkg::A_REMOTE_LO: rd_mux = {st_r.remote_t[1:0],
                                                 6'h00};
            temp_mon_pkg::A_OFS_HI:    rd_mux = st_r.ofs_h;
            temp_mon_pkg::A_OFS_LO:    rd_mux = st_r.ofs_l;
            temp_mon_pkg::A_RHI_LO:    rd_mux = st_r.rhi_l;
            temp_mon_pkg::A_RLO_LO:    rd_mux = st_r.rlo_l;
            temp_mon_pkg::A_RCRIT:     rd_mux = st_r.rcrit;
            temp_mon_pkg::A_LCRIT:     rd_mux = st_r.lcrit;
            temp_mon_pkg::A_HYST:      rd_mux = st_r.hyst;
            temp_mon_pkg::A_FILTER:    rd_mux = st_r.filt;
            temp_mon_pkg::A_MAKER:     rd_mux = MAKER_CODE;
            default:                   rd_mux = 8'h00;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.conv_start = 1'b0;
        st_nxt.rd_valid   = 1'b0;

        // host writes; status and read-only addresses fall to default
        if (wr_valid) begin
            if (wr_first) begin
                st_nxt.ptr = wr_data;
            end else begin
                case (st_r.ptr)
                    temp_mon_pkg::A_CFG_WR:  st_nxt.cfg   = wr_data;
                    temp_mon_pkg::A_RATE_WR: st_nxt.rate  = wr_data;
                    temp_mon_pkg::A_LHI_WR:  st_nxt.lhi   = wr_data;
                    temp_mon_pkg::A_LLO_WR:  st_nxt.llo   = wr_data;
                    temp_mon_pkg::A_RHI_WR:  st_nxt.rhi_h = wr_data;
                    temp_mon_pkg::A_RLO_WR:  st_nxt.rlo_h = wr_data;
                    temp_mon_pkg::A_OFS_HI:  st_nxt.ofs_h = wr_data;
                    temp_mon_pkg::A_OFS_LO:  st_nxt.ofs_l = wr_data;
                    temp_mon_pkg::A_RHI_LO:  st_nxt.rhi_l = wr_data;
                    temp_mon_pkg::A_RLO_LO:  st_nxt.rlo_l = wr_data;
                    temp_mon_pkg::A_RCRIT:   st_nxt.rcrit = wr_data;
                    temp_mon_pkg::A_LCRIT:   st_nxt.lcrit = wr_data;
                    temp_mon_pkg::A_HYST:    st_nxt.hyst  = wr_data;
                    temp_mon_pkg::A_FILTER:  st_nxt.filt  = wr_data;
                    temp_mon_pkg::A_ONESHOT: begin
                        // data byte is not kept
                        if (st_r.cfg[temp_mon_pkg::CFG_STBY]) begin
                            st_nxt.oneshot = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end

        if (rd_req) begin
            st_nxt.rd_valid = 1'b1;
            st_nxt.rd_data  = rd_mux;
        end

        // conversion sequencing
        case (st_r.conv)
            temp_mon_pkg::CV_IDLE: begin
                if ((!st_r.cfg[temp_mon_pkg::CFG_STBY] && conv_tick)
                    || st_r.oneshot) begin
                    st_nxt.conv       = temp_mon_pkg::CV_BUSY;
                    st_nxt.conv_start = 1'b1;
                    st_nxt.oneshot    = 1'b0;
                end
            end
            temp_mon_pkg::CV_BUSY: begin
                if (conv_done) begin
                    st_nxt.conv     = temp_mon_pkg::CV_IDLE;
                    st_nxt.local_t  = result.local_t;
                    st_nxt.remote_t = rc;
                    st_nxt.open_lvl = result.remote_open;
                    st_nxt.raw      = oob;
                    st_nxt.cond     = trip;
                    st_nxt.cnt      = cnt_new;
                end
            end
            default: st_nxt.conv = temp_mon_pkg::CV_IDLE;
        endcase

        // limit flags: clear on status read first, so a set wins
        for (int i = 0; i < 4; i++) begin
            if (!mode2) begin
                if (rd_req && st_r.ptr == temp_mon_pkg::A_STATUS
                    && !st_r.raw[i]) begin
                    st_nxt.flags[temp_mon_pkg::ST_LHI - i] = 1'b0;
                end
                if (done && trip[i]) begin
                    st_nxt.flags[temp_mon_pkg::ST_LHI - i] = 1'b1;
                end
            end
        end
        if (mode2) begin
            // low flags just follow the filtered level here
            st_nxt.flags[5] = st_nxt.cond[1];
            st_nxt.flags[3] = st_nxt.cond[3];
            if (st_r.cond[0]) begin
                st_nxt.flags[6] = 1'b1;
            end else if (at_floor(st_r.local_t, st_r.lhi, st_r.hyst)) begin
                st_nxt.flags[6] = 1'b0;
            end
            if (st_r.cond[2]) begin
                st_nxt.flags[4] = 1'b1;
            end else if (at_floor(st_r.remote_t[9:2], st_r.rhi_h,
                                  st_r.hyst)) begin
                st_nxt.flags[4] = 1'b0;
            end
        end
        if (rd_req && st_r.ptr == temp_mon_pkg::A_STATUS
            && !st_r.open_lvl) begin
            st_nxt.flags[temp_mon_pkg::ST_OPEN] = 1'b0;
        end
        if (done && result.remote_open) begin
            st_nxt.flags[temp_mon_pkg::ST_OPEN] = 1'b1;
        end

        // critical flags track the stored readings, even in standby
        if (st_r.local_t > st_r.lcrit) begin
            st_nxt.flags[temp_mon_pkg::ST_LCRIT] = 1'b1;
        end else if (at_floor(st_r.local_t, st_r.lcrit, st_r.hyst)) begin
            st_nxt.flags[temp_mon_pkg::ST_LCRIT] = 1'b0;
        end
        if (st_r.remote_t[9:2] > st_r.rcrit) begin
            st_nxt.flags[temp_mon_pkg::ST_RCRIT] = 1'b1;
        end else if (at_floor(st_r.remote_t[9:2], st_r.rcrit,
                              st_r.hyst)) begin
            st_nxt.flags[temp_mon_pkg::ST_RCRIT] = 1'b0;
        end

        // alarm latch ignores status reads
        if (mode2) begin
            st_nxt.alarm_latch = 1'b0;
        end else if (|st_r.flags[6:2]) begin
            st_nxt.alarm_latch = 1'b1;
        end else if (ara_ack && !fault) begin
            st_nxt.alarm_latch = 1'b0;
        end

        st_nxt.alarm_n = mode2
            ? !(st_nxt.flags[6] || st_nxt.flags[4])
            : !(st_nxt.alarm_latch
                && !st_r.cfg[temp_mon_pkg::CFG_MASK]);
        st_nxt.overtemp_n = !(st_nxt.flags[1] || st_nxt.flags[0]);
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r            <= '0;
            st_r.ptr        <= temp_mon_pkg::RST_PTR;
            st_r.cfg        <= temp_mon_pkg::RST_CFG;
            st_r.rate       <= temp_mon_pkg::RST_RATE;
            st_r.lhi        <= temp_mon_pkg::RST_HIGH;
            st_r.llo        <= temp_mon_pkg::RST_LOW;
            st_r.rhi_h      <= temp_mon_pkg::RST_HIGH;
            st_r.rlo_h      <= temp_mon_pkg::RST_LOW;
            st_r.rcrit      <= temp_mon_pkg::RST_CRIT;
            st_r.lcrit      <= temp_mon_pkg::RST_CRIT;
            st_r.hyst       <= temp_mon_pkg::RST_HYST;
            st_r.filt       <= temp_mon_pkg::RST_FILTER;
            st_r.conv       <= temp_mon_pkg::CV_IDLE;
            st_r.alarm_n    <= 1'b1;
            st_r.overtemp_n <= 1'b1;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign rd_data        = st_r.rd_data;
    assign rd_valid       = st_r.rd_valid;
    assign conv_start     = st_r.conv_start;
    assign alarm_out_n    = st_r.alarm_n;
    assign overtemp_out_n = st_r.overtemp_n;
    assign bus_timeout_en = st_r.filt[temp_mon_pkg::FLT_TMO];
    assign rate_code      = st_r.rate[temp_mon_pkg::RATE_MSB:0];

    // ==========================================================
    // checks
    a_busy_bit_read: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (ce && rd_req && st_r.ptr == temp_mon_pkg::A_STATUS)
        |=> rd_valid && rd_data[temp_mon_pkg::ST_BUSY]
            == ($past(st_r.conv) == temp_mon_pkg::CV_BUSY))
        else $error("busy bit does not match conversion state");

    a_local_high_set: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (ce && done && !mode2 && trip[0]) |=> st_r.flags[6])
        else $error("local high flag not set on trip");

    a_remote_high_set: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (ce && done && !mode2 && trip[2]) |=> st_r.flags[4])
        else $error("remote high flag not set on trip");

    a_open_flag_set: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (ce && done && result.remote_open) |=> st_r.flags[2])
        else $error("open flag not set");

    a_alarm_drive_low: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (ce && !mode2 && |st_r.flags[6:2]
         && !st_r.cfg[temp_mon_pkg::CFG_MASK])
        |=> !alarm_out_n && st_r.alarm_latch)
        else $error("alarm not driven for a set flag");

    a_latch_hold: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (ce && st_r.alarm_latch && !ara_ack && !mode2)
        |=> st_r.alarm_latch)
        else $error("alarm latch dropped without alert response");

    a_crit_out_level: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        overtemp_out_n == !(st_r.flags[1] || st_r.flags[0]))
        else $error("critical output disagrees with flags");

    a_crit_hyst_hold: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (ce && st_r.flags[temp_mon_pkg::ST_LCRIT]
         && !at_floor(st_r.local_t, st_r.lcrit, st_r.hyst))
        |=> st_r.flags[temp_mon_pkg::ST_LCRIT]
        ##0 !overtemp_out_n)
        else $error("local critical released above floor");

endmodule // temp_monitor_alarm_regs

// ==== verif/temp_host_model.sv ====
// Purpose: host side of the register path, byte strobes in and out
// Assumes: serial engine already decoded; strobes move at falling edge
// Notes:   pointer reloaded before every access
module temp_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    output logic            wr_valid = 1'b0,
    output logic            wr_first = 1'b0,
    output logic [7:0]      wr_data = 8'h00,
    output logic            rd_req = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // byte tasks
    task automatic put(input logic f, input logic [7:0] d);
        @(negedge ref_clk);
        wr_valid = 1'b1;
        wr_first = f;
        wr_data  = d;
        @(negedge ref_clk);
        wr_valid = 1'b0;
        wr_data  = ~d; // idle bus must not look like the last byte
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, a);
        put(1'b0, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        put(1'b1, a);
        rd_req = 1'b1;
        @(posedge ref_clk);
        #1;
        v = (rd_valid === 1'b1) ? rd_data : 8'hxx;
        @(negedge ref_clk);
        rd_req = 1'b0;
    endtask
endmodule // temp_host_model

// ==== verif/temp_monitor_alarm_regs_tb_top.sv ====
// Purpose: self-checking bench for the alarm and register block
// Assumes: filter at one reading, low limits left at zero
// Notes:   integer model of flags, latch and critical outputs
`define CHK(n, e, s) begin total_checks++; \
    if ((s) !== (e)) begin fails++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
module temp_monitor_alarm_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, sys_rst = 1'b1, ara_ack = 1'b0;
    logic conv_tick = 1'b0, conv_done = 1'b0;
    temp_mon_pkg::result_s result = '0;
    logic wr_valid, wr_first, rd_req, rd_valid, conv_start;
    logic alarm_out_n, overtemp_out_n, bus_timeout_en;
    logic [7:0] wr_data, rd_data, v, q;
    logic [3:0] rate_code;
    int fails = 0, total_checks = 0, ofs = 0, flags = 0, fault = 0;
    int latch = 0, lc = 0, rc = 0, r, hy = 10;
    always #2.5 ref_clk = ~ref_clk;
    temp_monitor_alarm_regs u_dut (.ref_clk, .sys_rst, .ce(1'b1),
        .wr_valid, .wr_first, .wr_data, .rd_req, .ara_ack, .conv_tick,
        .conv_done, .result, .rd_data, .rd_valid, .conv_start,
        .alarm_out_n, .overtemp_out_n, .bus_timeout_en, .rate_code);
    temp_host_model u_host (.ref_clk, .rd_data, .rd_valid, .wr_valid,
        .wr_first, .wr_data, .rd_req);
    // ==========================================================
    // tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk_status(input int busy);
        u_host.rd(temp_mon_pkg::A_STATUS, v);
        `CHK("status", 8'(busy << 7 | flags | rc << 1 | lc), v)
        flags = flags & fault;
    endtask
    task automatic ara();
        @(negedge ref_clk);
        ara_ack = 1'b1;
        @(negedge ref_clk);
        ara_ack = 1'b0;
        repeat (2) @(negedge ref_clk);
        if (flags == 0 && fault == 0) latch = 0;
        `CHK("alarm release", latch == 0, alarm_out_n)
    endtask
    task automatic conv(input logic [7:0] lt, input logic [9:0] rt,
                        input bit open, input bit shot);
        int i;
        @(negedge ref_clk);
        // write spans the edge that sets the pending start; the start launches one edge later
        if (shot) u_host.wr(temp_mon_pkg::A_ONESHOT, 8'($urandom));
        else begin
            conv_tick = 1'b1;
            @(negedge ref_clk);
            conv_tick = 1'b0;
        end
        for (i = 0; i < 8 && conv_start !== 1'b1; i++) @(negedge ref_clk);
        `CHK("conv start", 1'b1, conv_start)
        if (i == 8) finish_test();
        chk_status(1);
        result = {lt, rt, open};
        conv_done = 1'b1;
        @(negedge ref_clk);
        conv_done = 1'b0;
        repeat (3) @(negedge ref_clk);
        r = int'(rt) + ofs;
        r = r < 0 ? 0 : (r > 1023 ? 1023 : r);
        fault = (lt > 'h55) << 6 | (lt == 0) << 5 | (r > 'h55 * 4) << 4
              | (r == 0) << 3 | int'(open) << 2;
        flags |= fault;
        latch |= (flags != 0);
        lc = lt > 'h6c ? 1 : (lt <= 'h6c - hy ? 0 : lc);
        rc = r / 4 > 'h6c ? 1 : (r / 4 <= 'h6c - hy ? 0 : rc);
        `CHK("overtemp", !(lc | rc), overtemp_out_n)
        `CHK("alarm", latch == 0, alarm_out_n)
        chk_status(0);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] adr [8] = '{8'h05, 8'h07, 8'h19, 8'h20, 8'h21, 8'h22,
                                8'h04, 8'h03};
        logic [7:0] rst [8] = '{8'h55, 8'h55, 8'h6c, 8'h6c, 8'h0a, 8'h01,
                                8'h08, 8'h00};
        logic [7:0] crit [3] = '{8'h70, 8'h63, 8'h62};
        void'($urandom(32'hc2e5));
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        foreach (adr[k]) begin
            u_host.rd(adr[k], v);
            `CHK("reset value", rst[k], v)
        end
        `CHK("rate code", 4'h8, rate_code)
        `CHK("timeout enable", 1'b0, bus_timeout_en)
        $display("reset test done");
        u_host.wr(8'h02, 8'hff);
        q = 8'($urandom % 11);
        u_host.wr(8'h0a, q);
        u_host.rd(8'h04, v);
        `CHK("rate", q, v)
        `CHK("rate code", q[3:0], rate_code)
        u_host.wr(8'h22, 8'h80);
        `CHK("timeout enable", 1'b1, bus_timeout_en)
        u_host.wr(8'h11, 8'hfe);
        u_host.wr(8'h12, 8'h40);
        ofs = -7; // minus 1.75 degrees in quarter steps
        $display("register test done");
        conv(8'h56, 10'(8'h57 * 4 + 6), 1'b0, 1'b0);
        ara(); // fault still present, latch must hold
        conv(8'h40, 10'h100, 1'b0, 1'b0);
        ara();
        $display("alarm test done");
        foreach (crit[k]) conv(crit[k], 10'h100, 1'b0, 1'b0);
        $display("critical test done");
        conv(8'($urandom_range(1, 8'h50)), 10'($urandom_range(8, 'h150)),
             1'b1, 1'b0);
        u_host.wr(8'h09, 8'h40);
        conv(8'($urandom_range(1, 8'h50)), 10'h120, 1'b0, 1'b1);
        $display("open and single shot test done");
        u_host.wr(8'h09, 8'hc0);
        @(negedge ref_clk); // mask acts one edge after the write
        `CHK("alarm mask", 1'b1, alarm_out_n)
        u_host.wr(8'h09, 8'h60);
        @(negedge ref_clk);
        `CHK("second crit idle", 1'b1, alarm_out_n)
        conv(8'h60, 10'h100, 1'b0, 1'b1);
        conv(8'h50, 10'h100, 1'b0, 1'b1);
        $display("second critical test done");
        finish_test();
    end
endmodule // temp_monitor_alarm_regs_tb_top
